// >>> src/pere_top.sv
// Summary of operation
// - A misaligned control or padding character or an undefined code-group sets the code alignment flag, with no capture, cleared by writing zero.
// - An unexpected acknowledge symbol sets the stray acknowledge flag, cleared by writing zero.
// - A missing acknowledge or link response within the time-out sets the response timeout flag, with no capture.
// - A fault counts and is captured only while its enable bit is set.
// - A non-zero write to the flag register counts once when any written bit is enabled.
// - When the counter reaches its threshold an interrupt is raised and software may read and clear.
// - Enable bit 0 gates counting of vendor specific logical and transport faults.
// - Vendor captures are valid only for reserved transport and unmapped destination; max retry takes the last packet.
// - Enable bits 9 to 14 gate symbol CRC, symbol bad tag, rejected symbol, packet bad tag, packet CRC and oversize.
// - A packet longer than 276 bytes is an oversize fault.
// - Enable bits 26, 27, 29, 30, 31 gate stale tag, unexpected symbol, alignment, stray acknowledge and timeout.
// - A link response naming a retired tag is flagged and packet transfer holds until realignment.
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module pere_top
(
   // clock and reset
   input  wire logic                                             mclk,
   input  wire logic                                             rstn,
   // apb slave
   input  wire logic                                             psel,
   input  wire logic                                             penable,
   input  wire logic                                             pwrite,
   input  wire logic [31:0]                                      paddr,
   input  wire logic [31:0]                                      pwdata,
   output logic      [31:0]                                      prdata,
   output logic                                                  pready,
   output logic                                                  pslverr,
   // link fault events, one bit per port, one-cycle pulses
   input  wire logic [pere_pkg::NUM_PORTS-1:0]                   vendorRsvdTransport,
   input  wire logic [pere_pkg::NUM_PORTS-1:0]                   vendorUnmappedDest,
   input  wire logic [pere_pkg::NUM_PORTS-1:0]                   vendorMaxRetry,
   input  wire logic [pere_pkg::NUM_PORTS-1:0]                   vendorOther,
   input  wire logic [pere_pkg::NUM_PORTS-1:0]                   symbolCrcFault,
   input  wire logic [pere_pkg::NUM_PORTS-1:0]                   symbolBadTagFault,
   input  wire logic [pere_pkg::NUM_PORTS-1:0]                   rejectedSymbolFault,
   input  wire logic [pere_pkg::NUM_PORTS-1:0]                   packetBadTagFault,
   input  wire logic [pere_pkg::NUM_PORTS-1:0]                   packetChecksumFault,
   input  wire logic [pere_pkg::NUM_PORTS-1:0]                   staleResponseTagFault,
   input  wire logic [pere_pkg::NUM_PORTS-1:0]                   unexpectedSymbolFault,
   input  wire logic [pere_pkg::NUM_PORTS-1:0]                   codeAlignmentFault,
   input  wire logic [pere_pkg::NUM_PORTS-1:0]                   strayAcknowledgeFault,
   input  wire logic [pere_pkg::NUM_PORTS-1:0]                   responseTimeoutFault,
   // received packet end and its length in bytes
   input  wire logic [pere_pkg::NUM_PORTS-1:0]                   packetDone,
   input  wire logic [pere_pkg::NUM_PORTS-1:0][pere_pkg::LEN_W-1:0] packetLength,
   // tags realigned after a stale response
   input  wire logic [pere_pkg::NUM_PORTS-1:0]                   ackidRealigned,
   // capture requests and transfer hold, per port
   output logic      [pere_pkg::NUM_PORTS-1:0]                   captureStrobe,
   output logic      [pere_pkg::NUM_PORTS-1:0]                   captureLastPkt,
   output logic      [pere_pkg::NUM_PORTS-1:0]                   transferHold,
   // interrupt
   output logic                                                  irq
);

   localparam int NP = pere_pkg::NUM_PORTS;

   typedef struct packed
   {
      logic [NP-1:0][31:0]          flags;
      logic [NP-1:0][31:0]          enables;
      logic [NP-1:0]                hold;
      logic [NP-1:0]                irqStatus;
      logic [NP-1:0]                irqMask;
      logic [pere_pkg::CNT_W-1:0]   threshold;
      logic [31:0]                  rdata;
      logic                         slverr;
      logic                         irqOut;
   } pere_state_type;

   pere_state_type state_ff;
   pere_state_type nxt_state;

   logic [NP-1:0][31:0]             faultVector;
   logic [NP-1:0]                   countHit;
   logic [NP-1:0]                   testIncr;
   logic [NP-1:0]                   counterClear;
   logic [NP-1:0]                   reached;
   logic [NP-1:0][pere_pkg::CNT_W-1:0] count;

   // address decode shared by the setup and access phases
   logic                            inBlock;
   logic [3:0]                      portSel;
   logic [9:0]                      blockIdx;
   logic                            hitFlags;
   logic                            hitEnable;
   logic                            hitCount;
   logic [3:0]                      countSel;
   logic                            hitIrqStatus;
   logic                            hitIrqMask;
   logic                            hitThreshold;
   logic                            mapped;
   logic                            setupPhase;
   logic                            writeAccess;

   always_comb
   begin
      blockIdx     = paddr[15:6];
      inBlock      = (paddr[31:16] == 16'h0000)
                  && (blockIdx >= pere_pkg::BLOCK_FIRST)
                  && (blockIdx <= pere_pkg::BLOCK_LAST);
      portSel      = 4'(blockIdx - pere_pkg::BLOCK_FIRST);
      hitFlags     = inBlock && (paddr[5:0] == pere_pkg::FLAGS_OFS);
      hitEnable    = inBlock && (paddr[5:0] == pere_pkg::ENABLE_OFS);
      hitCount     = (paddr[31:10] == 22'(pere_pkg::COUNT_BASE >> 10))
                  && (paddr[1:0] == 2'h0)
                  && (paddr[9:2] >= pere_pkg::COUNT_FIRST)
                  && (paddr[9:2] <= pere_pkg::COUNT_LAST);
      countSel     = paddr[5:2];
      hitIrqStatus = (paddr == {16'h0000, pere_pkg::IRQ_STATUS});
      hitIrqMask   = (paddr == {16'h0000, pere_pkg::IRQ_MASK});
      hitThreshold = (paddr == {16'h0000, pere_pkg::THRESHOLD});
      mapped       = hitFlags | hitEnable | hitCount
                   | hitIrqStatus | hitIrqMask | hitThreshold;
      setupPhase   = psel && !penable;
      writeAccess  = psel && penable && pwrite && mapped;
   end

   genvar p;
   generate
      for (p = 0; p < NP; p++)
      begin : g_port
         pere_fault_decode u_decode
         (
            .vendorRsvdTransport   (vendorRsvdTransport[p]),
            .vendorUnmappedDest    (vendorUnmappedDest[p]),
            .vendorMaxRetry        (vendorMaxRetry[p]),
            .vendorOther           (vendorOther[p]),
            .symbolCrcFault        (symbolCrcFault[p]),
            .symbolBadTagFault     (symbolBadTagFault[p]),
            .rejectedSymbolFault   (rejectedSymbolFault[p]),
            .packetBadTagFault     (packetBadTagFault[p]),
            .packetChecksumFault   (packetChecksumFault[p]),
            .packetDone            (packetDone[p]),
            .packetLength          (packetLength[p]),
            .staleResponseTagFault (staleResponseTagFault[p]),
            .unexpectedSymbolFault (unexpectedSymbolFault[p]),
            .codeAlignmentFault    (codeAlignmentFault[p]),
            .strayAcknowledgeFault (strayAcknowledgeFault[p]),
            .responseTimeoutFault  (responseTimeoutFault[p]),
            .countEnable           (state_ff.enables[p]),
            .faultVector           (faultVector[p]),
            .countHit              (countHit[p]),
            .captureStrobe         (captureStrobe[p]),
            .captureLastPkt        (captureLastPkt[p])
         );

         // a test write counts once however many enabled bits it carries
         assign testIncr[p] = writeAccess && hitFlags && (portSel == 4'(p))
                           && ((pwdata & state_ff.enables[p] & pere_pkg::IMPL_MASK)
                               != 32'h0000_0000);
         assign counterClear[p] = writeAccess && hitCount && (countSel == 4'(p));

         pere_rate_counter u_counter
         (
            .mclk      (mclk),
            .rstn      (rstn),
            .increment (countHit[p] | testIncr[p]),
            .clear     (counterClear[p]),
            .threshold (state_ff.threshold),
            .count     (count[p]),
            .reached   (reached[p])
         );
      end
   endgenerate

   always_comb
   begin
      nxt_state = state_ff;
      for (int i = 0; i < NP; i++)
      begin
         // flags: a write of zero clears, a fault in the same cycle wins
         if (writeAccess && hitFlags && (portSel == 4'(i)))
         begin
            nxt_state.flags[i] = state_ff.flags[i] & pwdata;
         end
         nxt_state.flags[i] = (nxt_state.flags[i] | faultVector[i])
                            & pere_pkg::IMPL_MASK;
         if (writeAccess && hitEnable && (portSel == 4'(i)))
         begin
            nxt_state.enables[i] = pwdata & pere_pkg::IMPL_MASK;
         end
         // stale tag holds transfers until the link reports realignment
         if (ackidRealigned[i])
         begin
            nxt_state.hold[i] = 1'b0;
         end
         if (faultVector[i][pere_pkg::POS_STALE])
         begin
            nxt_state.hold[i] = 1'b1;
         end
      end
      if (writeAccess && hitIrqStatus)
      begin
         nxt_state.irqStatus = state_ff.irqStatus & ~pwdata[NP-1:0];
      end
      nxt_state.irqStatus = nxt_state.irqStatus | reached;
      if (writeAccess && hitIrqMask)
      begin
         nxt_state.irqMask = pwdata[NP-1:0];
      end
      if (writeAccess && hitThreshold)
      begin
         nxt_state.threshold = pwdata[pere_pkg::CNT_W-1:0];
      end
      nxt_state.irqOut = |(nxt_state.irqStatus & nxt_state.irqMask);
      // read data is sampled in the setup cycle so it leaves a flop
      if (setupPhase)
      begin
         nxt_state.slverr = !mapped;
         nxt_state.rdata  = 32'h0000_0000;
         if (!pwrite)
         begin
            if (hitFlags)
            begin
               nxt_state.rdata = state_ff.flags[portSel];
            end
            else if (hitEnable)
            begin
               nxt_state.rdata = state_ff.enables[portSel];
            end
            else if (hitCount)
            begin
               nxt_state.rdata = {24'h000000, count[countSel]};
            end
            else if (hitIrqStatus)
            begin
               nxt_state.rdata = {16'h0000, state_ff.irqStatus};
            end
            else if (hitIrqMask)
            begin
               nxt_state.rdata = {16'h0000, state_ff.irqMask};
            end
            else if (hitThreshold)
            begin
               nxt_state.rdata = {24'h000000, state_ff.threshold};
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_ff.flags     <= {NP{pere_pkg::FLAGS_RESET}};
         state_ff.enables   <= {NP{pere_pkg::ENABLE_RESET}};
         state_ff.hold      <= '0;
         state_ff.irqStatus <= pere_pkg::IRQ_RESET;
         state_ff.irqMask   <= pere_pkg::IRQ_RESET;
         state_ff.threshold <= pere_pkg::THRESHOLD_RESET;
         state_ff.rdata     <= 32'h0000_0000;
         state_ff.slverr    <= 1'b0;
         state_ff.irqOut    <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // zero-wait slave: answers in the first access cycle
   assign pready       = psel && penable;
   assign prdata       = state_ff.rdata;
   assign pslverr      = psel && penable && state_ff.slverr;
   assign transferHold = state_ff.hold;
   assign irq          = state_ff.irqOut;

endmodule

// >>> src/pere_pkg.sv
package pere_pkg;

   // port count and data widths
   localparam int          NUM_PORTS   = 16;
   localparam int          DATA_W      = 32;
   localparam int          LEN_W       = 12;
   localparam int          CNT_W       = 8;

   // register byte addresses; per-port blocks repeat every stride
   localparam logic [15:0] FLAGS_BASE  = 16'h1040;
   localparam logic [15:0] ENABLE_BASE = 16'h1044;
   localparam logic [15:0] COUNT_BASE  = 16'h0900;
   localparam logic [15:0] IRQ_STATUS  = 16'h0800;
   localparam logic [15:0] IRQ_MASK    = 16'h0804;
   localparam logic [15:0] THRESHOLD   = 16'h0808;
   localparam logic [9:0]  BLOCK_FIRST = 10'h041;
   localparam logic [9:0]  BLOCK_LAST  = 10'h050;
   localparam logic [5:0]  FLAGS_OFS   = 6'h00;
   localparam logic [5:0]  ENABLE_OFS  = 6'h04;
   localparam logic [7:0]  COUNT_FIRST = 8'h40;
   localparam logic [7:0]  COUNT_LAST  = 8'h4f;

   // bit 0 is the most significant bit, so hardware index is 31 minus the field number
   localparam int          POS_VENDOR    = 31 - 0;
   localparam int          POS_SYM_CRC   = 31 - 9;
   localparam int          POS_SYM_TAG   = 31 - 10;
   localparam int          POS_REJECT    = 31 - 11;
   localparam int          POS_PKT_TAG   = 31 - 12;
   localparam int          POS_PKT_CRC   = 31 - 13;
   localparam int          POS_OVERSIZE  = 31 - 14;
   localparam int          POS_STALE     = 31 - 26;
   localparam int          POS_UNEXP_SYM = 31 - 27;
   localparam int          POS_ALIGN     = 31 - 29;
   localparam int          POS_STRAY_ACK = 31 - 30;
   localparam int          POS_TIMEOUT   = 31 - 31;

   // implemented bits of both per-port registers; the rest read zero
   localparam logic [31:0] IMPL_MASK = 32'h8000_0000 | 32'h007e_0000
                                     | 32'h0000_0030 | 32'h0000_0007;
   // faults whose capture registers hold nothing useful
   localparam logic [31:0] NO_CAPTURE = 32'h0020_0000 | 32'h0000_0020
                                      | 32'h0000_0004 | 32'h0000_0001;

   localparam logic [31:0] FLAGS_RESET  = 32'h0000_0000;
   localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
   localparam logic [15:0] IRQ_RESET    = 16'h0000;
   localparam logic [CNT_W-1:0] THRESHOLD_RESET = 8'h10;
   localparam logic [LEN_W-1:0] MAX_PKT_BYTES   = 12'h114;

endpackage

// >>> src/pere_fault_decode.sv
`timescale 1ns/1ps
module pere_fault_decode
(
   // fault events of one port, one-cycle pulses
   input  wire logic                            vendorRsvdTransport,
   input  wire logic                            vendorUnmappedDest,
   input  wire logic                            vendorMaxRetry,
   input  wire logic                            vendorOther,
   input  wire logic                            symbolCrcFault,
   input  wire logic                            symbolBadTagFault,
   input  wire logic                            rejectedSymbolFault,
   input  wire logic                            packetBadTagFault,
   input  wire logic                            packetChecksumFault,
   input  wire logic                            packetDone,
   input  wire logic [pere_pkg::LEN_W-1:0]      packetLength,
   input  wire logic                            staleResponseTagFault,
   input  wire logic                            unexpectedSymbolFault,
   input  wire logic                            codeAlignmentFault,
   input  wire logic                            strayAcknowledgeFault,
   input  wire logic                            responseTimeoutFault,
   // count enables of this port
   input  wire logic [31:0]                     countEnable,
   // decoded results
   output logic [31:0]                          faultVector,
   output logic                                 countHit,
   output logic                                 captureStrobe,
   output logic                                 captureLastPkt
);

   logic oversize;
   logic vendorCounted;

   always_comb
   begin
      oversize = packetDone && (packetLength > pere_pkg::MAX_PKT_BYTES);
      faultVector = 32'h0000_0000;
      faultVector[pere_pkg::POS_VENDOR]    = vendorRsvdTransport | vendorUnmappedDest
                                           | vendorMaxRetry | vendorOther;
      faultVector[pere_pkg::POS_SYM_CRC]   = symbolCrcFault;
      faultVector[pere_pkg::POS_SYM_TAG]   = symbolBadTagFault;
      faultVector[pere_pkg::POS_REJECT]    = rejectedSymbolFault;
      faultVector[pere_pkg::POS_PKT_TAG]   = packetBadTagFault;
      faultVector[pere_pkg::POS_PKT_CRC]   = packetChecksumFault;
      faultVector[pere_pkg::POS_OVERSIZE]  = oversize;
      faultVector[pere_pkg::POS_STALE]     = staleResponseTagFault;
      faultVector[pere_pkg::POS_UNEXP_SYM] = unexpectedSymbolFault;
      faultVector[pere_pkg::POS_ALIGN]     = codeAlignmentFault;
      faultVector[pere_pkg::POS_STRAY_ACK] = strayAcknowledgeFault;
      faultVector[pere_pkg::POS_TIMEOUT]   = responseTimeoutFault;
      countHit = |(faultVector & countEnable & pere_pkg::IMPL_MASK);
      vendorCounted = countEnable[pere_pkg::POS_VENDOR] & faultVector[pere_pkg::POS_VENDOR];
      // only reserved transport and unmapped destination give valid vendor captures
      captureStrobe = |(faultVector & countEnable & pere_pkg::IMPL_MASK
                        & ~pere_pkg::NO_CAPTURE & ~(32'h8000_0000))
                    | (vendorCounted & (vendorRsvdTransport | vendorUnmappedDest));
      // a max-retry capture takes the last received packet, not the retried one
      captureLastPkt = vendorCounted & vendorMaxRetry & ~captureStrobe;
   end

endmodule

// >>> src/pere_rate_counter.sv
`timescale 1ns/1ps
module pere_rate_counter
(
   // clock and reset
   input  wire logic                       mclk,
   input  wire logic                       rstn,
   // control
   input  wire logic                       increment,
   input  wire logic                       clear,
   input  wire logic [pere_pkg::CNT_W-1:0] threshold,
   // status
   output logic [pere_pkg::CNT_W-1:0]      count,
   output logic                            reached
);

   typedef struct packed
   {
      logic [pere_pkg::CNT_W-1:0] count;
      logic                       reached;
   } pere_cnt_state_type;

   pere_cnt_state_type state_ff;
   pere_cnt_state_type nxt_state;

   always_comb
   begin
      nxt_state = state_ff;
      nxt_state.reached = 1'b0;
      if (clear)
      begin
         nxt_state.count = '0;
      end
      else if (increment && (state_ff.count != '1))
      begin
         // saturates so a storm of faults cannot wrap below the threshold
         nxt_state.count = state_ff.count + 1'b1;
         nxt_state.reached = (threshold != '0)
                          && (nxt_state.count == threshold);
      end
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   assign count   = state_ff.count;
   assign reached = state_ff.reached;

endmodule

// >>> tb/pere_asserts.sv
`timescale 1ns/1ps
module pere_asserts
(
   // clock, reset and bus
   input wire logic             mclk, rstn, psel, penable, pwrite,
   // link faults
   input wire logic [15:0]      vendorRsvdTransport, vendorUnmappedDest, vendorMaxRetry,
   input wire logic [15:0]      symbolCrcFault, rejectedSymbolFault, packetBadTagFault,
   input wire logic [15:0]      packetChecksumFault, unexpectedSymbolFault,
   input wire logic [15:0]      strayAcknowledgeFault, staleResponseTagFault,
   input wire logic [15:0]      ackidRealigned, packetDone,
   input wire logic [15:0][11:0] packetLength,
   // results
   input wire logic [15:0]      captureStrobe, captureLastPkt, transferHold,
   input wire logic             irq
);
   // faults whose capture holds something useful, oversize aside
   wire logic [15:0] capto = vendorRsvdTransport | vendorUnmappedDest | symbolCrcFault
      | rejectedSymbolFault | packetBadTagFault | packetChecksumFault
      | unexpectedSymbolFault | strayAcknowledgeFault;
   wire logic [15:0] holdSet = staleResponseTagFault & ~ackidRealigned;
   wire logic        apbWr = psel & penable & pwrite;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);

   a_capture_cause: assert property ((captureStrobe & ~(capto | packetDone)) == 16'h0)
      else $error("capture without a capturable fault");
   a_last_pkt: assert property ((captureLastPkt & ~vendorMaxRetry) == 16'h0)
      else $error("last packet capture without max retry");
   a_size_limit: assert property ((packetDone[0] && packetLength[0] <= 12'h114 && !capto[0])
      |-> !captureStrobe[0]) else $error("short packet captured as oversize");
   a_hold_set: assert property (holdSet != 16'h0
      |=> (transferHold & $past(holdSet)) == $past(holdSet)) else $error("hold not set");
   a_hold_cause: assert property ((transferHold & ~$past(transferHold)
      & ~$past(staleResponseTagFault)) == 16'h0) else $error("hold without stale tag");
   a_hold_keep: assert property ((~transferHold & $past(transferHold)
      & ~$past(ackidRealigned)) == 16'h0) else $error("hold dropped early");
   a_reset_quiet: assert property ($rose(rstn) |-> transferHold == 16'h0 && !irq)
      else $error("outputs not cleared by reset");
   a_irq_clear: assert property ($fell(irq) |-> $past(apbWr))
      else $error("irq fell without a register write");
endmodule

bind pere_top pere_asserts u_chk (.*);

// >>> tb/pere_link_partner.sv
`timescale 1ns/1ps
module pere_link_partner
(
   // clock
   input wire logic mclk,
   // fault kinds by index, packet end at index 14
   output logic [14:0][15:0] fault,
   output logic [15:0][11:0] packetLength
);
   initial
   begin
      fault = '0;
      packetLength = '0;
   end
   // one-cycle pulse; the port's length line keeps the inverted length once idle
   task automatic send(input int kind, input int port, input logic [11:0] len);
      @(posedge mclk);
      fault[kind][port] <= 1'h1;
      packetLength[port] <= len;
      @(posedge mclk);
      fault <= '0;
      packetLength[port] <= ~len;
   endtask
endmodule

// >>> tb/pere_tb_top.sv
`timescale 1ns/1ps
module pere_tb_top;
   logic mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, err;
   logic [31:0] paddr = '0, pwdata = '0, prdata, q, b;
   logic [15:0] vendorRsvdTransport, vendorUnmappedDest, vendorMaxRetry, vendorOther,
      symbolCrcFault, symbolBadTagFault, rejectedSymbolFault, packetBadTagFault,
      packetChecksumFault, staleResponseTagFault, unexpectedSymbolFault, codeAlignmentFault,
      strayAcknowledgeFault, responseTimeoutFault, packetDone, ackidRealigned = '0,
      captureStrobe, captureLastPkt, transferHold;
   logic [15:0][11:0] packetLength;
   logic [14:0][15:0] fault;
   int mismatches = 0, nCompared = 0;
   // rows: flag bit of each fault kind and whether it captures
   int pos[15] = '{31, 31, 31, 31, 22, 21, 20, 19, 18, 5, 4, 2, 1, 0, 17};
   logic [14:0] capt = 15'h55d3;
   assign {packetDone, responseTimeoutFault, strayAcknowledgeFault, codeAlignmentFault,
      unexpectedSymbolFault, staleResponseTagFault, packetChecksumFault, packetBadTagFault,
      rejectedSymbolFault, symbolBadTagFault, symbolCrcFault, vendorOther, vendorMaxRetry,
      vendorUnmappedDest, vendorRsvdTransport} = fault;
   pere_link_partner i_link (.mclk(mclk), .fault(fault), .packetLength(packetLength));
   pere_top i_dut (.*);
   always #4 mclk = ~mclk;

   function automatic logic [31:0] fa(int p, logic en);
      return {16'h0, en ? pere_pkg::ENABLE_BASE : pere_pkg::FLAGS_BASE} + 32'h40 * p;
   endfunction
   function automatic logic [31:0] ca(int p);
      return {16'h0, pere_pkg::COUNT_BASE} + 32'h4 * p;
   endfunction
   task automatic chk(input string s, input logic [31:0] e, g);
      nCompared++;
      if (g !== e)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic apb(input logic wr, input logic [31:0] a, d);
      int n = 0;
      @(posedge mclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'h1;
      do @(posedge mclk); while (pready !== 1'h1 && ++n < 16);
      if (n == 16) mismatches++;
      q = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rd(input string s, input logic [31:0] a, e);
      apb(1'h0, a, 32'h0);
      chk(s, e, q);
   endtask
   task automatic report_and_stop();
      if (mismatches == 0 && nCompared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (20) @(posedge mclk);
      rstn <= 1'h1;
      rd("flags reset", fa(0, 0), 32'h0);
      rd("enable reset", fa(0, 1), 32'h0);
      for (int i = 0; i < 15; i++)
      begin
         b = 32'h1 << pos[i];
         apb(1'h1, fa(i, 1), b);
         fork
            i_link.send(i, i, 12'h115);
            begin
               @(posedge mclk);
               #1 chk("capture", {31'h0, capt[i]}, {31'h0, captureStrobe[i]});
               chk("last packet", {31'h0, i == 2}, {31'h0, captureLastPkt[i]});
            end
         join
         rd("flag set", fa(i, 0), b);
         rd("count", ca(i), 32'h1);
         apb(1'h1, fa(i, 0), b);
         rd("test write", ca(i), 32'h2);
         apb(1'h1, fa(i, 0), 32'h0);
         rd("flag clear", fa(i, 0), 32'h0);
         apb(1'h1, ca(i), 32'h0);
         apb(1'h1, fa(i, 1), 32'h0);
      end
      i_link.send(11, 0, 12'h0);
      rd("flag no enable", fa(0, 0), 32'h4);
      rd("no count", ca(0), 32'h0);
      apb(1'h1, fa(0, 1), 32'hffffffff);
      rd("reserved", fa(0, 1), 32'h807e0037);
      apb(1'h1, fa(0, 0), 32'h8);
      i_link.send(14, 0, 12'h114);
      rd("flags 276", fa(0, 0), 32'h0);
      rd("count reserved", ca(0), 32'h0);
      apb(1'h1, {16'h0, pere_pkg::IRQ_MASK}, 32'h8000);
      apb(1'h1, {16'h0, pere_pkg::THRESHOLD}, 32'h2);
      apb(1'h1, fa(15, 1), 32'h2);
      i_link.send(12, 15, 12'h0);
      i_link.send(12, 15, 12'h0);
      repeat (4) @(posedge mclk);
      chk("irq raised", 32'h1, {31'h0, irq});
      apb(1'h1, {16'h0, pere_pkg::IRQ_MASK}, 32'h0);
      #1 chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'h1, {16'h0, pere_pkg::IRQ_STATUS}, 32'h8000);
      apb(1'h1, {16'h0, pere_pkg::IRQ_MASK}, 32'h8000);
      #1 chk("irq cleared", 32'h0, {31'h0, irq});
      chk("hold", 32'h1, {31'h0, transferHold[9]});
      @(posedge mclk);
      ackidRealigned[9] <= 1'h1;
      @(posedge mclk);
      ackidRealigned <= '0;
      #1 chk("hold release", 32'h0, {31'h0, transferHold[9]});
      rd("unmapped data", 32'h100, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      report_and_stop();
   end

   initial
   begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      report_and_stop();
   end
endmodule
